// file: tmr_clk_pkg.sv
// Constants and carrier types for the timer clock select and prescaler
`default_nettype none
package tmr_clk_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] TIMER_CLOCK_SELECT_ADDR = 8'h8E;
    localparam logic [7:0] TIMER_CLOCK_SELECT_RESET = 8'h00;
    localparam int TMR3_HIGH_BIT = 7;
    localparam int TMR3_LOW_BIT = 6;
    localparam int TMR2_HIGH_BIT = 5;
    localparam int TMR2_LOW_BIT = 4;
    localparam int TMR1_BIT = 3;
    localparam int TMR0_BIT = 2;
    localparam int PRESCALE_LSB = 0;
    // ------------------------------------------------------------
    // Divider counts
    // ------------------------------------------------------------
    localparam int DIV_SYS_12 = 12;
    localparam int DIV_SYS_4 = 4;
    localparam int DIV_SYS_48 = 48;
    localparam int DIV_EXT_8 = 8;
    localparam logic [5:0] SYS_CNT_RESET = 6'h00;
    localparam logic [2:0] EXT_CNT_RESET = 3'h0;
    // Synchroniser idle levels: external clock low, event pins high
    localparam logic [2:0] SYNC_IDLE = 3'h6;

    typedef enum logic [1:0]
    {
        PRESCALE_SYS_12 = 2'b00,
        PRESCALE_SYS_4 = 2'b01,
        PRESCALE_SYS_48 = 2'b10,
        PRESCALE_EXT_8 = 2'b11
    } prescale_t;

    typedef struct packed
    {
        logic tmr3_high_sysclk_sel;
        logic tmr3_low_sysclk_sel;
        logic tmr2_high_sysclk_sel;
        logic tmr2_low_sysclk_sel;
        logic tmr1_sysclk_sel;
        logic tmr0_sysclk_sel;
        prescale_t shared_prescale_sel;
    } timer_clock_select_t;

    // One count-enable per timer counter
    typedef struct packed
    {
        logic tmr3_high;
        logic tmr3_low;
        logic tmr2_high;
        logic tmr2_low;
        logic tmr1;
        logic tmr0;
    } timer_ticks_t;

    // Register access port from the core
    typedef struct packed
    {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : tmr_clk_pkg
`default_nettype wire

// file: timer_clock_select_prescaler.sv
// Timer clock source selection and shared prescaler producing count enables
`default_nettype none
module timer_clock_select_prescaler
    import tmr_clk_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic ext_osc,
    input wire logic tmr0_event_count_sel,
    input wire logic tmr1_event_count_sel,
    input wire logic tmr0_pin,
    input wire logic tmr1_pin,
    input wire logic tmr2_alt_clock_sel,
    input wire logic tmr3_alt_clock_sel,
    output timer_ticks_t ticks
);
    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    timer_clock_select_t timer_clock_select_q;
    logic [7:0] reg_rdata_q;
    logic reg_hit;
    logic reg_write;
    logic reg_read;

    // True when the access targets the clock select register
    function automatic logic addr_hit(input logic [7:0] addr);
        addr_hit = (addr == TIMER_CLOCK_SELECT_ADDR);
    endfunction : addr_hit

    assign reg_hit = addr_hit(reg_req.addr);
    assign reg_write = reg_req.wr && reg_hit;
    assign reg_read = reg_req.rd && reg_hit;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_clock_select_q <= timer_clock_select_t'(TIMER_CLOCK_SELECT_RESET);
        end
        else if (reg_write)
        begin
            timer_clock_select_q <= timer_clock_select_t'(reg_req.wdata);
        end
    end

    // Read data stands one cycle; other addresses read as zero
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_q <= 8'h00;
        end
        else if (reg_read)
        begin
            reg_rdata_q <= timer_clock_select_q;
        end
        else
        begin
            reg_rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_q;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    assign pin_raw = {tmr1_pin, tmr0_pin, ext_osc};

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            logic [2:0] sync_q;
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sync_q <= {3{SYNC_IDLE[g]}};
                end
                else
                begin
                    sync_q <= {sync_q[1:0], pin_raw[g]};
                end
            end
            // Edge detect on second and third stages only
            assign pin_rise[g] = sync_q[1] & ~sync_q[2];
            assign pin_fall[g] = ~sync_q[1] & sync_q[2];
        end
    endgenerate

    logic ext_rise;
    logic t0_fall;
    logic t1_fall;
    assign ext_rise = pin_rise[0];
    assign t0_fall = pin_fall[1];
    assign t1_fall = pin_fall[2];

    // ------------------------------------------------------------
    // Free-running dividers
    // ------------------------------------------------------------
    logic [5:0] sys_cnt_q;
    logic [2:0] ext_cnt_q;

    // One counter modulo 48 serves 4, 12 and 48, which all divide it
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sys_cnt_q <= SYS_CNT_RESET;
        end
        else if (sys_cnt_q == 6'(DIV_SYS_48 - 1))
        begin
            sys_cnt_q <= SYS_CNT_RESET;
        end
        else
        begin
            sys_cnt_q <= sys_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_cnt_q <= EXT_CNT_RESET;
        end
        else if (ext_rise)
        begin
            ext_cnt_q <= ext_cnt_q + 3'h1;
        end
    end

    // Pulses; each at most one cycle, shared by all consumers so no double pulse
    logic div4_en;
    logic div12_en;
    logic div48_en;
    logic ext8_en;
    assign div4_en = sys_cnt_q[1:0] == 2'(DIV_SYS_4 - 1);
    assign div12_en = (sys_cnt_q == 6'(DIV_SYS_12 - 1)) || (sys_cnt_q == 6'(2 * DIV_SYS_12 - 1))
        || (sys_cnt_q == 6'(3 * DIV_SYS_12 - 1)) || (sys_cnt_q == 6'(DIV_SYS_48 - 1));
    assign div48_en = sys_cnt_q == 6'(DIV_SYS_48 - 1);
    assign ext8_en = ext_rise && ext_cnt_q == 3'(DIV_EXT_8 - 1);

    // ------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------
    function automatic logic prescale_tick(input prescale_t sel, input logic d4, input logic d12,
                                           input logic d48, input logic e8);
        case (sel)
            PRESCALE_SYS_12: prescale_tick = d12;
            PRESCALE_SYS_4: prescale_tick = d4;
            PRESCALE_SYS_48: prescale_tick = d48;
            PRESCALE_EXT_8: prescale_tick = e8;
            default: prescale_tick = 1'b0;
        endcase
    endfunction : prescale_tick

    // Alternate source for timers 2 and 3: sys/12 or ext/8
    function automatic logic alt_tick(input logic sel, input logic d12, input logic e8);
        alt_tick = sel ? e8 : d12;
    endfunction : alt_tick

    logic shared_tick;
    logic tmr2_alt_tick;
    logic tmr3_alt_tick;
    assign shared_tick = prescale_tick(timer_clock_select_q.shared_prescale_sel, div4_en, div12_en,
                                       div48_en, ext8_en);
    assign tmr2_alt_tick = alt_tick(tmr2_alt_clock_sel, div12_en, ext8_en);
    assign tmr3_alt_tick = alt_tick(tmr3_alt_clock_sel, div12_en, ext8_en);

    // ------------------------------------------------------------
    // Per-timer tick selection
    // ------------------------------------------------------------
    logic tmr3_high_d;
    logic tmr3_low_d;
    logic tmr2_high_d;
    logic tmr2_low_d;
    logic tmr1_d;
    logic tmr0_d;
    timer_ticks_t ticks_d;

    always_comb
    begin
        if (timer_clock_select_q.tmr3_high_sysclk_sel)
        begin
            tmr3_high_d = 1'b1;
        end
        else
        begin
            tmr3_high_d = tmr3_alt_tick;
        end
    end

    always_comb
    begin
        if (timer_clock_select_q.tmr3_low_sysclk_sel)
        begin
            tmr3_low_d = 1'b1;
        end
        else
        begin
            tmr3_low_d = tmr3_alt_tick;
        end
    end

    always_comb
    begin
        if (timer_clock_select_q.tmr2_high_sysclk_sel)
        begin
            tmr2_high_d = 1'b1;
        end
        else
        begin
            tmr2_high_d = tmr2_alt_tick;
        end
    end

    always_comb
    begin
        if (timer_clock_select_q.tmr2_low_sysclk_sel)
        begin
            tmr2_low_d = 1'b1;
        end
        else
        begin
            tmr2_low_d = tmr2_alt_tick;
        end
    end

    // Event counting overrides the clock select bit
    always_comb
    begin
        if (tmr1_event_count_sel)
        begin
            tmr1_d = t1_fall;
        end
        else if (timer_clock_select_q.tmr1_sysclk_sel)
        begin
            tmr1_d = 1'b1;
        end
        else
        begin
            tmr1_d = shared_tick;
        end
    end

    // Event counting overrides the clock select bit
    always_comb
    begin
        if (tmr0_event_count_sel)
        begin
            tmr0_d = t0_fall;
        end
        else if (timer_clock_select_q.tmr0_sysclk_sel)
        begin
            tmr0_d = 1'b1;
        end
        else
        begin
            tmr0_d = shared_tick;
        end
    end

    always_comb
    begin
        ticks_d.tmr3_high = tmr3_high_d;
        ticks_d.tmr3_low = tmr3_low_d;
        ticks_d.tmr2_high = tmr2_high_d;
        ticks_d.tmr2_low = tmr2_low_d;
        ticks_d.tmr1 = tmr1_d;
        ticks_d.tmr0 = tmr0_d;
    end

    // Registered ticks: glitch free, change seen one cycle after a write
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ticks <= '0;
        end
        else
        begin
            ticks <= ticks_d;
        end
    end
endmodule : timer_clock_select_prescaler
`default_nettype wire

// file: timer_clock_select_prescaler_sva.sv
// Checker for register access and tick selection of the timer clock block
`default_nettype none
module timer_clock_select_prescaler_sva
    import tmr_clk_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic tmr0_event_count_sel,
    input wire logic tmr1_event_count_sel,
    input wire logic tmr2_alt_clock_sel,
    input wire timer_ticks_t ticks
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sel_q;
    logic [5:0] cnt_q;
    logic rd_hit;
    logic h12;
    logic hit;
    assign rd_hit = reg_req.rd && reg_req.addr == TIMER_CLOCK_SELECT_ADDR;
    assign h12 = cnt_q % 12 == 11;
    assign hit = sel_q[1] ? (!sel_q[0] && cnt_q == 6'h2F) : sel_q[0] ? cnt_q[1:0] == 2'h3 : h12;
    // Shadow of the select register and of the free-running divide phase
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            sel_q <= TIMER_CLOCK_SELECT_RESET;
        else if (reg_req.wr && reg_req.addr == TIMER_CLOCK_SELECT_ADDR)
            sel_q <= reg_req.wdata;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            cnt_q <= SYS_CNT_RESET;
        else
            cnt_q <= cnt_q == 6'h2F ? 6'h00 : cnt_q + 6'h01;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_rd_value: assert property (rd_hit |=> reg_rdata == $past(sel_q))
        else $error("read data differs from register");
    a_rd_idle: assert property (!rd_hit |=> reg_rdata == 8'h00)
        else $error("idle read data not zero");
    a_upper_sysclk: assert property (sel_q[7:4] != 4'h0 |=>
        (ticks[5:2] & $past(sel_q[7:4])) == $past(sel_q[7:4]))
        else $error("upper timer tick missing");
    a_t2_alt_div: assert property (!sel_q[4] && !tmr2_alt_clock_sel |=> ticks.tmr2_low == $past(h12))
        else $error("timer 2 divide by twelve wrong");
    a_t0_sysclk: assert property (sel_q[2] && !tmr0_event_count_sel |=> ticks.tmr0)
        else $error("timer 0 system tick missing");
    a_t1_sysclk: assert property (sel_q[3] && !tmr1_event_count_sel |=> ticks.tmr1)
        else $error("timer 1 system tick missing");
    a_t0_prescaled: assert property (!sel_q[2] && sel_q[1:0] != 2'h3 && !tmr0_event_count_sel |=>
        ticks.tmr0 == $past(hit))
        else $error("timer 0 prescaled tick wrong");
    a_t1_prescaled: assert property (!sel_q[3] && sel_q[1:0] != 2'h3 && !tmr1_event_count_sel |=>
        ticks.tmr1 == $past(hit))
        else $error("timer 1 prescaled tick wrong");
endmodule : timer_clock_select_prescaler_sva
bind timer_clock_select_prescaler timer_clock_select_prescaler_sva i_sva (.core_clk, .rst_n, .reg_req, .reg_rdata,
    .tmr0_event_count_sel, .tmr1_event_count_sel, .tmr2_alt_clock_sel, .ticks);
`default_nettype wire

// file: tick_counters.sv
// Timer counters that consume the selected count enables
`default_nettype none
module tick_counters
    import tmr_clk_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire timer_ticks_t ticks,
    output logic [5:0][15:0] cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            cnt <= '0;
        else
            for (int i = 0; i < 6; i++)
                cnt[i] <= cnt[i] + 16'(ticks[i]);
endmodule : tick_counters
`default_nettype wire

// file: timer_clock_select_prescaler_bench.sv
// Self-checking bench for the timer clock select and prescaler
`default_nettype none
module timer_clock_select_prescaler_bench
    import tmr_clk_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst_n = 0, ext_osc = 0, alt2 = 0, alt3 = 0;
    logic [1:0] ev = 2'h0, pin = 2'h3, r;
    logic [7:0] cfg, rdata;
    reg_req_t req = '0;
    timer_ticks_t ticks;
    logic [5:0][15:0] cnt, snap;
    logic [15:0] got;
    int exp_cnt;
    int num_errors = 0, n_tests = 0, seed = 32'hDA2F32ED, ph = 0, falls[2], div[4] = '{12, 4, 48, 48};
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        ph <= (ph + 1) % 3;
        if (ph == 2)
            ext_osc <= ~ext_osc;
    end
    timer_clock_select_prescaler i_dut (.core_clk, .rst_n, .reg_req(req), .reg_rdata(rdata), .ext_osc,
        .tmr0_event_count_sel(ev[0]), .tmr1_event_count_sel(ev[1]), .tmr0_pin(pin[0]), .tmr1_pin(pin[1]),
        .tmr2_alt_clock_sel(alt2), .tmr3_alt_clock_sel(alt3), .ticks);
    tick_counters i_cnt (.core_clk, .rst_n, .ticks, .cnt);
    task give_verdict;
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task check_reg(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
            $display("BAD %0t got %h exp %h", $time, got, exp);
        num_errors += int'(got !== exp);
    endtask : check_reg
    task check_cnt(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
            $display("BAD %0t got %h exp %h", $time, got, exp);
        num_errors += int'(got !== exp);
    endtask : check_cnt
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk) req <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge core_clk) req <= '0;
        #1 check_reg(rdata, exp);
    endtask : rd
    // Watchdog against a hung run
    initial
    begin
        #200000;
        num_errors++;
        give_verdict;
    end
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(TIMER_CLOCK_SELECT_ADDR, 8'h00);
        for (int k = 0; k < 32; k++)
        begin
            cfg = 8'($random(seed));
            cfg[3:0] = 4'(k);
            @(posedge core_clk) {alt3, alt2, ev} <= {3'($random(seed)), k[4]};
            @(posedge core_clk) req <= '{TIMER_CLOCK_SELECT_ADDR, 1'b1, 1'b0, cfg};
            @(posedge core_clk) req <= '0;
            rd(TIMER_CLOCK_SELECT_ADDR, cfg);
            rd(8'h8F, 8'h00);
            snap = cnt;
            falls = '{0, 0};
            // Event pins held three cycles per level, quiet near the window end
            repeat (158)
            begin
                r = 2'($random(seed));
                falls[0] += int'(pin[0] && !r[0]);
                falls[1] += int'(pin[1] && !r[1]);
                @(posedge core_clk) pin <= r;
                repeat (2) @(posedge core_clk);
            end
            @(posedge core_clk) pin <= 2'h3;
            repeat (5) @(posedge core_clk);
            #1;
            for (int i = 0; i < 6; i++)
            begin
                got = cnt[i] - snap[i];
                exp_cnt = (i < 2 && ev[i]) ? falls[i] : cfg[i + 2] ? 480
                    : i < 2 ? 480 / div[cfg[1:0]] : (i < 4 ? alt2 : alt3) ? 10 : 40;
                if (i < 2)
                    check_cnt(got, 16'(exp_cnt));
                else
                    check_cnt(got, 16'(exp_cnt));
            end
        end
        give_verdict;
    end
endmodule : timer_clock_select_prescaler_bench
`default_nettype wire
